// ### verilog/negnorm_defs.svh
/*
 Timing-free constants for the negate / normalize / wide multiply datapath.
 Assumes inclusion by bare name from the design module.
*/
`ifndef NEGNORM_DEFS_SVH
`define NEGNORM_DEFS_SVH
`define WORD_MIN 32'h8000_0000
`define WORD_MAX 32'h7fff_ffff
`define HALF_MIN 16'h8000
`define HALF_MAX 32'h0000_7fff
`define NORM32_ALL 5'h1f
`define NORM16_ALL 4'hf
`define MID_LSB 16
`define HI_LSB 32
`define IDLE_SHORT_CODE 16'h78e0
`define HALF_ZERO 16'h0000
`define HALF_WIDTH 16
`define HALF_SIGN_BIT 15
`define SIGN_BIT 31
`define BORROW_BIT 32
`define ZERO_WORD 32'h0000_0000
`endif

// ### verilog/negnorm_pkg.sv
/*
 Types for the negate / normalize / wide multiply datapath.
 Assumes the defines header sits on the include path.
*/
package negnorm_pkg;
	typedef enum logic [3:0] {
		op_idle,
		op_invert_sign,
		op_saturating_sign_invert,
		op_saturating_halfword_sign_invert,
		op_leading_sign_count,
		op_halfword_leading_sign_count,
		op_unsigned_wide_product,
		op_product_high_restore
	} op_kind_t;

	typedef struct packed {
		logic valid;
		op_kind_t op;
		logic cond_true;
		logic set_flags;
		logic [31:0] src1;
		logic [31:0] src2;
	} issue_t;

	typedef struct packed {
		logic z;
		logic n;
		logic c;
		logic v;
		logic sat_sticky;
		logic sat_first;
		logic sat_second;
	} flags_t;

	typedef struct packed {
		logic res_valid;
		logic [31:0] result;
		logic flags_we;
		flags_t flags;
		logic [31:0] prod_lo;
		logic [31:0] prod_mid;
		logic [31:0] prod_hi;
	} state_t;
endpackage

// ### verilog/negnorm_unit.sv
/*
 Execution datapath: negate, saturating negates, leading-sign counts and the
 unsigned 32x32 wide product with its three result registers.
 Assumes decode presents one issue per cycle with the condition already
 evaluated, and that write-back consumes result/flags one cycle later.
*/
`timescale 1ns/1ns
`include "negnorm_defs.svh"
module negnorm_unit (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire negnorm_pkg::issue_t issue,
	input wire negnorm_pkg::flags_t flags_in,
	output negnorm_pkg::state_t state_out
);
	negnorm_pkg::state_t st_ff;
	negnorm_pkg::state_t nxt_st;

	// Count of leading copies of the sign bit after the sign, i.e. the shift to normalize
	function automatic logic [4:0] sign_count32(input logic [31:0] x);
		logic [4:0] cnt;
		logic done;
		cnt = 5'h0;
		done = 1'b0;
		for (int i = 30; i >= 0; i--) begin
			if (!done && x[i] == x[31]) begin
				cnt = cnt + 5'h1;
			end else begin
				done = 1'b1;
			end
		end
		return cnt;
	endfunction

	// Zero minus the operand, shared by the plain and saturating word negates
	function automatic logic [31:0] negate(input logic [31:0] x);
		return `ZERO_WORD - x;
	endfunction

	// Borrow out of the reverse subtract from zero; it becomes the carry flag
	function automatic logic negate_borrow(input logic [31:0] x);
		logic [32:0] wide;
		wide = {1'b0, `ZERO_WORD} - {1'b0, x};
		return wide[`BORROW_BIT];
	endfunction

	// Only the most negative word has no positive counterpart
	function automatic logic word_saturates(input logic [31:0] x);
		return x == `WORD_MIN;
	endfunction

	// Same hazard for the low half on its own
	function automatic logic half_saturates(input logic [15:0] h);
		return h == `HALF_MIN;
	endfunction

	function automatic logic is_zero(input logic [31:0] x);
		return x == `ZERO_WORD;
	endfunction

	// Clamps instead of wrapping, so the result keeps the sign that negation promises
	function automatic logic [31:0] sat_negate_word(input logic [31:0] x);
		logic [31:0] r;
		if (word_saturates(x)) begin
			r = `WORD_MAX;
		end else begin
			r = negate(x);
		end
		return r;
	endfunction

	// The upper half mirrors the sign of the 16-bit result, never the source's upper half
	function automatic logic [31:0] sat_negate_half(input logic [15:0] h);
		logic [31:0] r;
		logic [15:0] n16;
		n16 = `HALF_ZERO - h;
		if (half_saturates(h)) begin
			r = `HALF_MAX;
		end else begin
			r = {{`HALF_WIDTH{n16[`HALF_SIGN_BIT]}}, n16};
		end
		return r;
	endfunction

	// Zero and all-ones hold no sign change at all, so the count tops out
	function automatic logic [31:0] count_word(input logic [31:0] x);
		logic [31:0] r;
		if (is_zero(x) || x == ~`ZERO_WORD) begin
			r = {27'h0, `NORM32_ALL};
		end else begin
			r = {27'h0, sign_count32(x)};
		end
		return r;
	endfunction

	// The low half is moved to the top so the word counter is reused unchanged
	function automatic logic [31:0] count_half(input logic [15:0] h);
		logic [31:0] r;
		if (h == `HALF_ZERO || h == ~`HALF_ZERO) begin
			r = {28'h0, `NORM16_ALL};
		end else begin
			r = {27'h0, sign_count32({h, `HALF_ZERO})};
		end
		return r;
	endfunction

	// Z and N follow the value given; C, V and the saturation bits pass through
	function automatic negnorm_pkg::flags_t with_zn(input negnorm_pkg::flags_t f, input logic [31:0] x);
		negnorm_pkg::flags_t r;
		r = f;
		r.z = is_zero(x);
		r.n = x[`SIGN_BIT];
		return r;
	endfunction

	// Overflow mirrors saturation; the saturation bits are only ever set here, never cleared
	function automatic negnorm_pkg::flags_t with_sat(input negnorm_pkg::flags_t f, input logic sat);
		negnorm_pkg::flags_t r;
		r = f;
		r.v = sat;
		if (sat) begin
			r.sat_sticky = 1'b1;
			r.sat_first = 1'b1;
			r.sat_second = 1'b1;
		end
		return r;
	endfunction

	logic taken;
	logic [63:0] product;
	logic [15:0] low_half;
	logic [31:0] neg_word;
	logic [31:0] sat_word;
	logic [31:0] sat_half;
	logic [31:0] cnt_word;
	logic [31:0] cnt_half;

	always_comb begin
		taken = issue.valid && issue.cond_true;
		product = {32'h0000_0000, issue.src1} * {32'h0000_0000, issue.src2};
		low_half = issue.src1[15:0];
		// The plain negate is the reverse subtract from a zero immediate
		neg_word = negate(issue.src1);
		sat_word = sat_negate_word(issue.src1);
		sat_half = sat_negate_half(low_half);
		cnt_word = count_word(issue.src1);
		cnt_half = count_half(low_half);
		nxt_st = st_ff;
		nxt_st.res_valid = 1'b0;
		nxt_st.flags_we = 1'b0;
		// Untouched bits carry the live flags so write-back copies the whole field
		nxt_st.flags = flags_in;
		if (taken) begin
			unique case (issue.op)
				negnorm_pkg::op_idle: begin
				end

				negnorm_pkg::op_invert_sign: begin
					nxt_st.res_valid = 1'b1;
					nxt_st.result = neg_word;
					if (issue.set_flags) begin
						nxt_st.flags_we = 1'b1;
						nxt_st.flags = with_zn(flags_in, neg_word);
						nxt_st.flags.c = negate_borrow(issue.src1);
						// Zero minus x overflows only for the most negative word
						nxt_st.flags.v = word_saturates(issue.src1);
					end
				end

				negnorm_pkg::op_saturating_sign_invert: begin
					nxt_st.res_valid = 1'b1;
					nxt_st.result = sat_word;
					if (issue.set_flags) begin
						nxt_st.flags_we = 1'b1;
						// Carry is deliberately left alone
						nxt_st.flags = with_sat(with_zn(flags_in, sat_word), word_saturates(issue.src1));
					end
				end

				negnorm_pkg::op_saturating_halfword_sign_invert: begin
					nxt_st.res_valid = 1'b1;
					nxt_st.result = sat_half;
					if (issue.set_flags) begin
						nxt_st.flags_we = 1'b1;
						// Z and N come from the full sign-extended word
						nxt_st.flags = with_sat(with_zn(flags_in, sat_half), half_saturates(low_half));
					end
				end

				negnorm_pkg::op_leading_sign_count: begin
					nxt_st.res_valid = 1'b1;
					nxt_st.result = cnt_word;
					if (issue.set_flags) begin
						nxt_st.flags_we = 1'b1;
						// Flags describe the source, not the count
						nxt_st.flags = with_zn(flags_in, issue.src1);
					end
				end

				negnorm_pkg::op_halfword_leading_sign_count: begin
					nxt_st.res_valid = 1'b1;
					nxt_st.result = cnt_half;
					if (issue.set_flags) begin
						nxt_st.flags_we = 1'b1;
						// Low half placed on top gives Z from the half and N from its bit 15
						nxt_st.flags = with_zn(flags_in, {low_half, `HALF_ZERO});
					end
				end

				negnorm_pkg::op_unsigned_wide_product: begin
					// All three land in one edge so a reader never sees a mixed set
					nxt_st.prod_lo = product[31:0];
					nxt_st.prod_mid = product[`MID_LSB +: 32];
					nxt_st.prod_hi = product[`HI_LSB +: 32];
					// No flag write-enable here, whatever the set-flag bit says
				end

				negnorm_pkg::op_product_high_restore: begin
					// The low part is restored by software through a multiply by one
					nxt_st.prod_hi = issue.src1;
				end
				default: begin
				end
			endcase
		end
		// A false condition falls through above with nothing touched
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign state_out = st_ff;
endmodule

// ### test/negnorm_props.sv
/* Port checker for the negate / normalize / wide product unit.
 Assumes a bind onto every negnorm_unit instance. */
`timescale 1ns/1ns
module negnorm_props (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire negnorm_pkg::issue_t issue,
	input wire negnorm_pkg::flags_t flags_in,
	input wire negnorm_pkg::state_t state_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire t = issue.valid && issue.cond_true;
	wire [3:0] op = issue.op;
	wire [31:0] s = issue.src1;
	wire [31:0] n = 32'h0000_0000 - issue.src1;
	wire [63:0] p = issue.src1 * issue.src2;
	wire [31:0] m = p[47:16];
	property p_prod;
		t && op == 4'h6 |=> {state_out.prod_hi, state_out.prod_lo} == $past(p) && state_out.prod_mid == $past(m);
	endproperty
	a_prod: assert property (p_prod) else $error("product split wrong");
	property p_cond;
		issue.valid && !issue.cond_true |=> $stable(state_out.prod_lo) && !state_out.res_valid;
	endproperty
	a_cond: assert property (p_cond) else $error("false condition acted");
	property p_rest;
		t && op == 4'h7 |=> state_out.prod_hi == $past(s) && $stable(state_out.prod_lo);
	endproperty
	a_rest: assert property (p_rest) else $error("restore wrong");
	property p_quiet;
		t && (op == 4'h6 || op == 4'h0) |=> !state_out.flags_we && !state_out.res_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("quiet op wrote");
	property p_neg;
		t && op == 4'h1 |=> state_out.result == $past(n);
	endproperty
	a_neg: assert property (p_neg) else $error("negate wrong");
	property p_fset;
		issue.valid && !issue.set_flags |=> !state_out.flags_we;
	endproperty
	a_fset: assert property (p_fset) else $error("flags written");
	property p_sat;
		t && op == 4'h2 && s == 32'h8000_0000 && issue.set_flags |=> state_out.result == 32'h7fff_ffff
			&& state_out.flags.v && state_out.flags.sat_first && state_out.flags.sat_second;
	endproperty
	a_sat: assert property (p_sat) else $error("saturation wrong");
	property p_leading_sign_count_op;
		t && op == 4'h4 && (s == 32'h0000_0000 || s == 32'hffff_ffff) |=> state_out.result == 32'h0000_001f;
	endproperty
	a_leading_sign_count_op: assert property (p_leading_sign_count_op) else $error("count wrong");
	property p_half;
		t && op == 4'h3 && s[15:0] == 16'h8000 |=> state_out.result == 32'h0000_7fff;
	endproperty
	a_half: assert property (p_half) else $error("halfword clamp wrong");
endmodule
bind negnorm_unit negnorm_props chk_u (.mclk(mclk), .sys_rst(sys_rst), .issue(issue), .flags_in(flags_in),
	.state_out(state_out));

// ### test/negnorm_wb.sv
/* Write-back side model: keeps the flag register.
 Assumes the unit's state_out feeds it every cycle. */
`timescale 1ns/1ns
module negnorm_wb (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire negnorm_pkg::state_t state_out,
	output negnorm_pkg::flags_t flags_ff
);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flags_ff <= '0;
		end else if (state_out.flags_we) begin
			flags_ff <= state_out.flags;
		end
	end
endmodule

// ### test/negnorm_unit_test.sv
/* Self-checking bench for the negate / normalize unit.
 Assumes results appear one cycle after issue. */
`timescale 1ns/1ns
module negnorm_unit_test;
	typedef struct packed {
		logic [3:0] op;
		logic [31:0] s;
		logic [31:0] e;
	} row_t;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	negnorm_pkg::issue_t iss = '0;
	negnorm_pkg::flags_t flg;
	negnorm_pkg::state_t st;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	row_t rows[11] = '{'{4'h1, 32'h0000_0001, 32'hffff_ffff}, '{4'h1, 32'h8000_0000, 32'h8000_0000},
		'{4'h2, 32'h8000_0000, 32'h7fff_ffff}, '{4'h2, 32'h0000_0005, 32'hffff_fffb},
		'{4'h3, 32'h0000_8000, 32'h0000_7fff}, '{4'h3, 32'hffff_8001, 32'h0000_7fff},
		'{4'h3, 32'h0001_0003, 32'hffff_fffd}, '{4'h4, 32'hc000_0000, 32'h0000_0001},
		'{4'h4, 32'hffff_ffff, 32'h0000_001f}, '{4'h5, 32'h0000_0001, 32'h0000_000e},
		'{4'h5, 32'hffff_e000, 32'h0000_0002}};
	negnorm_unit dut_u (.mclk(mclk), .sys_rst(sys_rst), .issue(iss), .flags_in(flg), .state_out(st));
	negnorm_wb wb_u (.mclk(mclk), .sys_rst(sys_rst), .state_out(st), .flags_ff(flg));
	initial begin
		forever #2 mclk = ~mclk;
	end
	task final_report;
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input logic [35:0] got, input logic [35:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task go(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b, input logic sf, input logic cc);
		@(negedge mclk);
		iss = '{1'b1, negnorm_pkg::op_kind_t'(op), cc, sf, a, b};
		@(negedge mclk);
		iss.valid = 1'b0;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 400) begin
			fail_count++;
			final_report;
		end
	end
	initial begin
		repeat (12) @(negedge mclk);
		sys_rst = 1'b0;
		foreach (rows[i]) begin
			go(rows[i].op, rows[i].s, 32'h0000_0000, 1'b1, 1'b1);
			chk({st.res_valid, st.flags_we, st.result}, {2'b11, rows[i].e});
		end
		go(4'h6, 32'hffff_ffff, 32'h0001_0002, 1'b0, 1'b1);
		chk({st.flags_we, st.prod_hi}, {1'b0, 32'h0001_0001});
		chk(st.prod_mid, 32'h0001_fffe);
		go(4'h6, 32'h0000_0002, 32'h0000_0003, 1'b0, 1'b0);
		chk(st.prod_lo, 32'hfffe_fffe);
		go(4'h7, 32'h1234_5678, 32'h0000_0000, 1'b0, 1'b1);
		chk({st.prod_hi}, 32'h1234_5678);
		go(4'h2, 32'h8000_0000, 32'h0000_0000, 1'b1, 1'b1);
		chk({st.flags.c, st.flags.v, st.flags.sat_sticky, st.flags.sat_first, st.flags.sat_second}, {flg.c, 4'hf});
		go(4'h3, 32'h0000_8000, 32'h0000_0000, 1'b1, 1'b1);
		chk({st.flags.c, st.flags.v, st.flags.z, st.flags.n}, {flg.c, 3'h4});
		go(4'h4, 32'h0000_0000, 32'h0000_0000, 1'b1, 1'b1);
		chk({st.flags.z, st.flags.n}, 2'h2);
		go(4'h5, 32'hffff_0000, 32'h0000_0000, 1'b1, 1'b1);
		chk({st.flags.z, st.flags.n, st.result}, {2'h2, 32'h0000_000f});
		go(4'h1, 32'h0000_0001, 32'h0000_0000, 1'b1, 1'b1);
		chk({st.flags.z, st.flags.n, st.flags.c, st.flags.v}, 4'h6);
		go(4'h1, 32'h0000_0005, 32'h0000_0000, 1'b0, 1'b1);
		chk(st.flags_we, 1'b0);
		go(4'h0, 32'h0000_0005, 32'h0000_0000, 1'b1, 1'b1);
		chk({st.res_valid, st.flags_we}, 2'h0);
		sys_rst = 1'b1;
		@(negedge mclk);
		chk(st.prod_hi, 32'h0000_0000);
		final_report;
	end
endmodule
